/* include/shr_pkg.sv */
// Shared constants and types for the home return and position tracking block.
package shr_pkg;
    localparam int POS_W              = 32;
    localparam int REV_W              = 16;
    localparam int CYC_W              = 16;
    localparam int SPD_W              = 16;
    localparam int ACC_W              = 16;
    localparam int PT_LOW_W           = 5;
    localparam int PT_HIGH_W          = 3;
    localparam logic [REV_W-1:0] REV_LIMIT = 16'h7fff;
    localparam logic [3:0] ABS_INCR_DIGIT  = 4'h0;
    localparam int ROLL_DIGIT_LSB     = 4;
    localparam logic [3:0] ROLL_DIGIT_VAL  = 4'h1;
    localparam int DIR_POS_BIT        = 0;

    typedef enum logic [1:0] {
        SHR_MOVE_STOP,
        SHR_MOVE_FWD,
        SHR_MOVE_REV
    } shr_move_t;

    typedef enum logic [2:0] {
        SHR_IDLE,
        SHR_SEEK,
        SHR_BACK,
        SHR_PASS,
        SHR_HOMING,
        SHR_AUTOPOS
    } shr_state_t;
endpackage : shr_pkg

/* tb/shr_axis_model.sv */
// Axis stand-in for the home tracker: positions, stroke ends, proximity dog and completion pulses.
`timescale 1ns/1ps
module shr_axis_model
    import shr_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  shr_pkg::shr_move_t      moveCmd,
    input  wire logic               homingSeqStart,
    input  wire logic               noDog,
    input  wire logic               autoMode,
    input  wire logic               loadPos,
    input  wire logic signed [15:0] newPos,
    output logic                    fwdEnd,
    output logic                    revEnd,
    output logic                    dog,
    output logic                    homeDone,
    output logic                    moveDone
);
    import shr_pkg::*;
    int pos;
    int run;
    int hold;
    // Stroke ends sit at +-20, the dog covers 10 to 12 and can be removed to force the no-dog case.
    assign fwdEnd = (pos >= 20);
    assign revEnd = (pos <= -20);
    assign dog    = !noDog && (pos >= 10) && (pos <= 12);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pos      <= 0;
            run      <= 0;
            hold     <= 0;
            homeDone <= 1'b0;
            moveDone <= 1'b0;
        end else begin
            if (loadPos) pos <= newPos;
            else if (moveCmd == SHR_MOVE_FWD) pos <= pos + 1;
            else if (moveCmd == SHR_MOVE_REV) pos <= pos - 1;
            hold     <= homingSeqStart ? 3 : (hold > 0 ? hold - 1 : 0);
            homeDone <= (hold == 1);
            run      <= (autoMode && moveCmd == SHR_MOVE_REV) ? run + 1 : 0;
            moveDone <= (run == 4);
        end
    end
endmodule : shr_axis_model

/* tb/tb_top.sv */
// Self-checking bench for the home tracker with an axis stand-in.
`timescale 1ns/1ps
module tb_top;
    import shr_pkg::*;
    logic sys_clk, rst, powerOn, homeStart, dogRet, homeDirPos, amSel, rvs, fwdSw, revSw, dog, hDone, mDone;
    logic strokeless, incrCmd, gearChg, homeChg, erased, cntWarn, revStep, revUp, noDog, autoMode, loadPos;
    logic [4:0]  ptLow;
    logic [2:0]  ptHigh;
    logic [15:0] speed, acc, dec, absParam, dispParam, cycPos, cycOut, newPos, spdOut, accOut, decOut;
    logic [31:0] posMin, posMax, curPos, cmdPos, dispCur, dispCmd, rnd;
    logic signed [15:0] revCount;
    shr_move_t   moveCmd;
    logic        seqStart, softLim, alarm, homeValid, absEn, rollAct, revOvf;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          expRev;
    shr_home_tracker DUT (.sys_clk(sys_clk), .rst(rst), .powerOnPulse(powerOn), .homeStart(homeStart),
        .dogReturnEnable(dogRet), .homeDirPositive(homeDirPos), .auto_manual_select_bit(amSel),
        .point_table_select_low_bits(ptLow), .point_table_select_high_bits(ptHigh),
        .reverse_rotation_start_input(rvs), .forward_stroke_end_switch(fwdSw), .reverse_stroke_end_switch(revSw),
        .proximityDog(dog), .homeDone(hDone), .moveDone(mDone), .home_return_speed_param(speed),
        .pointOneAccel(acc), .pointOneDecel(dec), .absolute_detection_param(absParam),
        .display_function_select_param(dispParam), .strokelessSystem(strokeless), .incrementalCommand(incrCmd),
        .gearParamChanged(gearChg), .homeParamChanged(homeChg), .absolute_position_erased_alarm(erased),
        .absolute_counter_warning(cntWarn), .posMin(posMin), .posMax(posMax), .cycPos(cycPos), .revStep(revStep),
        .revUp(revUp), .curPos(curPos), .cmdPos(cmdPos), .moveCmd(moveCmd), .homingSeqStart(seqStart),
        .moveSpeed(spdOut), .moveAccel(accOut), .moveDecel(decOut), .softLimitEnable(softLim),
        .home_return_incomplete_alarm(alarm),
        .homeValid(homeValid), .absEnabled(absEn), .rollFeedActive(rollAct), .dispCurPos(dispCur),
        .dispCmdPos(dispCmd), .revCount(revCount), .cycPosOut(cycOut), .revOverflow(revOvf));
    shr_axis_model AXIS (.sys_clk(sys_clk), .rst(rst), .moveCmd(moveCmd), .homingSeqStart(seqStart),
        .noDog(noDog), .autoMode(autoMode), .loadPos(loadPos), .newPos(newPos), .fwdEnd(fwdSw),
        .revEnd(revSw), .dog(dog), .homeDone(hDone), .moveDone(mDone));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction : xs
    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic chkv(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chkv
    task automatic chkm(input string nm, input shr_move_t e);
        cmp_count++;
        if (moveCmd !== e) begin
            fail_count++;
            $display("ERROR %s expected %0d seen %0d", nm, e, moveCmd);
        end
    endtask : chkm
    // Bounded wait at the falling edge for a motion request or for the home reference.
    task automatic waitFor(input bit home, input shr_move_t m);
        int n;
        n = 0;
        while ((home ? homeValid !== 1'b1 : moveCmd !== m) && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 300) begin
            fail_count++;
            $display("ERROR wait expected %0d seen %0d", m, moveCmd);
            stop_test();
        end
    endtask : waitFor
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
        @(negedge sys_clk);
    endtask : pulse
    task automatic startHome();
        newPos = 16'sd15;
        pulse(loadPos);
        homeStart = 1'b1;
        @(negedge sys_clk);
        homeStart = 1'b0;
        chkm("seek direction", SHR_MOVE_FWD);
        chkv("soft limit off", 0, softLim);
        waitFor(0, SHR_MOVE_REV);
        waitFor(0, SHR_MOVE_STOP);
    endtask : startHome
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rnd = 32'h689b;
        {powerOn, homeStart, rvs, strokeless, incrCmd, gearChg, homeChg, erased, cntWarn} = '0;
        {revStep, revUp, noDog, autoMode, loadPos, newPos, cycPos, absParam, dispParam} = '0;
        {amSel, ptLow, ptHigh, dogRet, homeDirPos} = {1'b1, 8'h00, 2'b11};
        speed = 16'(xs());
        acc = 16'(xs());
        dec = 16'(xs());
        {posMin, posMax, curPos, cmdPos} = {-32'sd100, 32'sd100, 64'h0};
        rst = 1'b1;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        chkm("move at reset", SHR_MOVE_STOP);
        chkv("home at reset", 0, homeValid);
        pulse(rvs);
        chkm("autopos no home", SHR_MOVE_STOP);
        $display("Test reset and refusal done");
        startHome();
        waitFor(1, SHR_MOVE_STOP);
        chkv("no alarm", 0, alarm);
        $display("Test return beyond dog done");
        dispParam = 16'h0010;
        autoMode = 1'b1;
        curPos = xs() & 32'h3f;
        cmdPos = curPos + 32'h5;
        #1 chkv("roll active", 1, rollAct);
        pulse(rvs);
        chkm("autopos request", SHR_MOVE_REV);
        chkv("speed", speed, spdOut);
        chkv("accel", {acc, dec}, {accOut, decOut});
        chkv("soft limit off", 0, softLim);
        chkv("roll disp", 0, dispCur | dispCmd);
        curPos = curPos + 32'h7;
        #1 chkv("roll disp move", 7, dispCur);
        waitFor(0, SHR_MOVE_STOP);
        absParam = 16'h0001;
        #1 chkv("roll with abs", 0, rollAct);
        chkv("abs on", 1, absEn);
        strokeless = 1'b1;
        #1 chkv("abs strokeless", 0, absEn);
        {strokeless, incrCmd} = 2'b01;
        #1 chkv("abs incr cmd", 0, absEn);
        {incrCmd, absParam, dispParam, autoMode} = '0;
        curPos = 32'd200;
        pulse(rvs);
        chkm("autopos out of range", SHR_MOVE_STOP);
        curPos = 32'd0;
        $display("Test positioning to home done");
        erased = 1'b1;
        @(negedge sys_clk);
        erased = 1'b0;
        chkv("erased clears home", 0, homeValid);
        startHome();
        waitFor(1, SHR_MOVE_STOP);
        absParam = 16'h0001;
        pulse(powerOn);
        chkv("home kept", 1, homeValid);
        pulse(gearChg);
        pulse(powerOn);
        chkv("home dropped", 0, homeValid);
        pulse(powerOn);
        chkv("no home restored", 0, homeValid);
        absParam = 16'h0000;
        noDog = 1'b1;
        homeStart = 1'b1;
        @(negedge sys_clk);
        homeStart = 1'b0;
        waitFor(0, SHR_MOVE_REV);
        waitFor(0, SHR_MOVE_STOP);
        chkv("no dog alarm", 1, alarm);
        chkv("soft limit idle", 1, softLim);
        {noDog, newPos} = {1'b0, 16'sd11};
        pulse(loadPos);
        @(negedge sys_clk);
        homeStart = 1'b1;
        @(negedge sys_clk);
        homeStart = 1'b0;
        chkm("dog start return", SHR_MOVE_REV);
        waitFor(1, SHR_MOVE_STOP);
        chkv("dog start alarm clear", 0, alarm);
        $display("Test absolute and alarm done");
        expRev = 0;
        revUp = 1'b1;
        for (int i = 0; i < 32773; i++) begin
            if (i == 32770) revUp = 1'b0;
            cycPos = 16'(xs());
            expRev = revUp ? (expRev < 32767 ? expRev + 1 : 32767) : expRev - 1;
            pulse(revStep);
            chkv("within rev", cycPos, cycOut);
        end
        chkv("rev count", expRev, 32'(revCount));
        chkv("rev overflow", 1, revOvf);
        $display("Test revolution count done");
        stop_test();
    end
endmodule : tb_top

/* verilog/shr_home_tracker.sv */
// Home return sequencing, positioning to home and absolute position tracking.
// What this block does
// - Start beyond the dog: move home direction, reverse on either stroke end.
// - On return, stop past the dog front end, then resume normal home return.
// - Dog never seen on return: stop at stroke end and raise incomplete alarm.
// - Software limits are disabled during automatic return or positioning to home.
// - No positioning to home when current position is outside valid range.
// - With absolute detection, home reference survives power cycles.
// - Manual home mode, home known, reverse start positions axis to home.
// - Positioning to home uses home return speed and table entry one ramps.
// - Roll feed display works only with incremental system, no absolute detection.
// - Display function parameter setting selects roll feed display.
// - Roll feed display clears current and command position at each start.
// - Roll feed alters only displays; operation modes behave as normal.
// - Gear, direction or home data change discards home at next power-on.
// - Multi-revolution count spans plus or minus 32767 revolutions about home.
// - Absolute position is revolution count plus within-revolution position.
// - No absolute detection for strokeless or incremental-command positioning.
// - Start on the dog: automatic return off the dog before home return.
`timescale 1ns/1ps
module shr_home_tracker
    import shr_pkg::*;
#(
    parameter int CYC_BITS = CYC_W
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       powerOnPulse,
    input  wire logic                       homeStart,
    input  wire logic                       dogReturnEnable,
    input  wire logic                       homeDirPositive,
    input  wire logic                       auto_manual_select_bit,
    input  wire logic [PT_LOW_W-1:0]        point_table_select_low_bits,
    input  wire logic [PT_HIGH_W-1:0]       point_table_select_high_bits,
    input  wire logic                       reverse_rotation_start_input,
    input  wire logic                       forward_stroke_end_switch,
    input  wire logic                       reverse_stroke_end_switch,
    input  wire logic                       proximityDog,
    input  wire logic                       homeDone,
    input  wire logic                       moveDone,
    input  wire logic [SPD_W-1:0]           home_return_speed_param,
    input  wire logic [ACC_W-1:0]           pointOneAccel,
    input  wire logic [ACC_W-1:0]           pointOneDecel,
    input  wire logic [15:0]                absolute_detection_param,
    input  wire logic [15:0]                display_function_select_param,
    input  wire logic                       strokelessSystem,
    input  wire logic                       incrementalCommand,
    input  wire logic                       gearParamChanged,
    input  wire logic                       homeParamChanged,
    input  wire logic                       absolute_position_erased_alarm,
    input  wire logic                       absolute_counter_warning,
    input  wire logic [POS_W-1:0]           posMin,
    input  wire logic [POS_W-1:0]           posMax,
    input  wire logic [CYC_BITS-1:0]        cycPos,
    input  wire logic                       revStep,
    input  wire logic                       revUp,
    input  wire logic [POS_W-1:0]           curPos,
    input  wire logic [POS_W-1:0]           cmdPos,
    output shr_pkg::shr_move_t              moveCmd,
    output logic                            homingSeqStart,
    output logic [SPD_W-1:0]                moveSpeed,
    output logic [ACC_W-1:0]                moveAccel,
    output logic [ACC_W-1:0]                moveDecel,
    output logic                            softLimitEnable,
    output logic                            home_return_incomplete_alarm,
    output logic                            homeValid,
    output logic                            absEnabled,
    output logic                            rollFeedActive,
    output logic [POS_W-1:0]                dispCurPos,
    output logic [POS_W-1:0]                dispCmdPos,
    output logic signed [REV_W-1:0]         revCount,
    output logic [CYC_BITS-1:0]             cycPosOut,
    output logic                            revOverflow
);
    typedef struct packed {
        shr_state_t                 state;
        shr_move_t                  move;
        logic                       seqStart;
        logic                       alarm;
        logic                       home;
        logic                       paramDirty;
        logic                       seenDog;
        logic                       revStartPrev;
        logic                       homeStartPrev;
        logic                       rollStartPrev;
        logic [POS_W-1:0]           curOfs;
        logic [POS_W-1:0]           cmdOfs;
        logic signed [REV_W-1:0]    rev;
        logic [CYC_BITS-1:0]        cyc;
        logic                       ovf;
        logic                       lsp1, lsp2, lsn1, lsn2, dog1, dog2;
    } shr_regs_t;

    shr_regs_t st_reg;
    shr_regs_t st_next;
    logic      manualHomeMode;
    logic      absMode;
    logic      rollMode;
    logic      inRange;
    logic      anyStroke;
    logic      startEdge;
    logic      revEdge;
    logic      fwdDir;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode.
    assign manualHomeMode = auto_manual_select_bit && (point_table_select_low_bits == '0)
                            && (point_table_select_high_bits == '0);
    assign absMode  = (absolute_detection_param[3:0] != ABS_INCR_DIGIT)
                      && !strokelessSystem && !incrementalCommand;
    assign rollMode = (display_function_select_param[ROLL_DIGIT_LSB +: 4] == ROLL_DIGIT_VAL)
                      && !absMode;
    assign inRange   = ($signed(curPos) >= $signed(posMin)) && ($signed(curPos) <= $signed(posMax));
    assign anyStroke = st_reg.lsp2 || st_reg.lsn2;
    assign startEdge = homeStart && !st_reg.homeStartPrev;
    assign revEdge   = reverse_rotation_start_input && !st_reg.revStartPrev;
    assign fwdDir    = homeDirPositive;

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        st_next = st_reg;
        st_next.lsp1 = forward_stroke_end_switch;
        st_next.lsp2 = st_reg.lsp1;
        st_next.lsn1 = reverse_stroke_end_switch;
        st_next.lsn2 = st_reg.lsn1;
        st_next.dog1 = proximityDog;
        st_next.dog2 = st_reg.dog1;
        st_next.seqStart      = 1'b0;
        st_next.homeStartPrev = homeStart;
        st_next.revStartPrev  = reverse_rotation_start_input;
        st_next.rollStartPrev = homeStart || reverse_rotation_start_input;
        // A power-on keeps a home only if one existed; a change in that same cycle counts for the next power-on.
        if (powerOnPulse) begin
            st_next.home = st_reg.home && absMode && !st_reg.paramDirty;
            st_next.paramDirty = 1'b0;
        end
        if (gearParamChanged || homeParamChanged) begin
            st_next.paramDirty = 1'b1;
        end
        if (absolute_position_erased_alarm || absolute_counter_warning) begin
            st_next.home = 1'b0;
        end
        unique case (st_reg.state)
            SHR_IDLE: begin
                st_next.move = SHR_MOVE_STOP;
                if (startEdge && manualHomeMode && dogReturnEnable) begin
                    st_next.alarm = 1'b0;
                    st_next.seenDog = 1'b0;
                    if (st_reg.dog2) begin
                        st_next.state = SHR_BACK;
                        st_next.move  = fwdDir ? SHR_MOVE_REV : SHR_MOVE_FWD;
                    end else begin
                        st_next.state = SHR_SEEK;
                        st_next.move  = fwdDir ? SHR_MOVE_FWD : SHR_MOVE_REV;
                    end
                end else if (revEdge && manualHomeMode && st_reg.home && inRange) begin
                    st_next.state = SHR_AUTOPOS;
                    st_next.move  = SHR_MOVE_REV;
                end
            end
            SHR_SEEK: begin
                if (st_reg.dog2) begin
                    st_next.state    = SHR_HOMING;
                    st_next.move     = SHR_MOVE_STOP;
                    st_next.seqStart = 1'b1;
                end else if (anyStroke) begin
                    st_next.state = SHR_BACK;
                    st_next.move  = fwdDir ? SHR_MOVE_REV : SHR_MOVE_FWD;
                end
            end
            SHR_BACK: begin
                if (st_reg.dog2) begin
                    st_next.state   = SHR_PASS;
                    st_next.seenDog = 1'b1;
                end else if (anyStroke && st_reg.move != (fwdDir ? SHR_MOVE_FWD : SHR_MOVE_REV)
                             && !st_reg.seenDog && (fwdDir ? st_reg.lsn2 : st_reg.lsp2)) begin
                    st_next.state = SHR_IDLE;
                    st_next.move  = SHR_MOVE_STOP;
                    st_next.alarm = 1'b1;
                end
            end
            SHR_PASS: begin
                if (!st_reg.dog2) begin
                    st_next.state    = SHR_HOMING;
                    st_next.move     = SHR_MOVE_STOP;
                    st_next.seqStart = 1'b1;
                end
            end
            SHR_HOMING: begin
                st_next.move = SHR_MOVE_STOP;
                if (homeDone) begin
                    st_next.state = SHR_IDLE;
                    st_next.home  = 1'b1;
                end
            end
            SHR_AUTOPOS: begin
                if (moveDone) begin
                    st_next.state = SHR_IDLE;
                    st_next.move  = SHR_MOVE_STOP;
                end
            end
            default: begin
                st_next.state = SHR_IDLE;
                st_next.move  = SHR_MOVE_STOP;
            end
        endcase
        if (rollMode && (homeStart || reverse_rotation_start_input) && !st_reg.rollStartPrev) begin
            st_next.curOfs = curPos;
            st_next.cmdOfs = cmdPos;
        end
        st_next.cyc = cycPos;
        if (revStep) begin
            if (revUp && st_reg.rev != $signed(REV_LIMIT)) begin
                st_next.rev = st_reg.rev + 16'sh0001;
            end else if (!revUp && st_reg.rev != -$signed(REV_LIMIT)) begin
                st_next.rev = st_reg.rev - 16'sh0001;
            end else begin
                st_next.ovf = 1'b1;
            end
        end
        if (st_reg.state == SHR_HOMING && homeDone) begin
            st_next.rev = '0;
            st_next.ovf = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign moveCmd         = st_reg.move;
    assign homingSeqStart  = st_reg.seqStart;
    assign moveSpeed       = home_return_speed_param;
    assign moveAccel       = pointOneAccel;
    assign moveDecel       = pointOneDecel;
    assign softLimitEnable = (st_reg.state == SHR_IDLE) || (st_reg.state == SHR_HOMING);
    assign home_return_incomplete_alarm = st_reg.alarm;
    assign homeValid       = st_reg.home;
    assign absEnabled      = absMode;
    assign rollFeedActive  = rollMode;
    assign dispCurPos      = rollMode ? curPos - st_reg.curOfs : curPos;
    assign dispCmdPos      = rollMode ? cmdPos - st_reg.cmdOfs : cmdPos;
    assign revCount        = st_reg.rev;
    assign cycPosOut       = st_reg.cyc;
    assign revOverflow     = st_reg.ovf;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    chk_stroke_reverse: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg.state == SHR_SEEK && !st_reg.dog2 && anyStroke |=> st_reg.state == SHR_BACK)
        else $error("seek did not reverse at stroke end");
    chk_pass_restart: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg.state == SHR_PASS && !st_reg.dog2 |=> homingSeqStart && moveCmd == SHR_MOVE_STOP)
        else $error("home return not resumed after dog front end");
    chk_alarm_stop: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(home_return_incomplete_alarm) |-> moveCmd == SHR_MOVE_STOP && st_reg.state == SHR_IDLE)
        else $error("alarm raised while moving");
    chk_softlimit_off: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg.state inside {SHR_SEEK, SHR_BACK, SHR_PASS, SHR_AUTOPOS} |-> !softLimitEnable)
        else $error("soft limit active in automatic return");
    chk_autopos_range: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg.state == SHR_IDLE && revEdge && !inRange && !startEdge |=> st_reg.state == SHR_IDLE)
        else $error("positioning to home from outside range");
    chk_autopos_go: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg.state == SHR_IDLE && revEdge && manualHomeMode && homeValid && inRange && !startEdge
        |=> st_reg.state == SHR_AUTOPOS)
        else $error("positioning to home not started");
    chk_no_home_idle: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg.state == SHR_IDLE && !homeValid && !startEdge |=> moveCmd == SHR_MOVE_STOP)
        else $error("axis moved without a valid home");
    chk_power_home: assert property (@(posedge sys_clk) disable iff (rst)
        powerOnPulse && st_reg.paramDirty && !absolute_position_erased_alarm |=> !homeValid)
        else $error("home kept after parameter change");
    chk_rev_bound: assert property (@(posedge sys_clk) disable iff (rst)
        revCount <= $signed(REV_LIMIT) && revCount >= -$signed(REV_LIMIT))
        else $error("revolution count out of range");
    chk_roll_abs: assert property (@(posedge sys_clk) disable iff (rst)
        rollFeedActive |-> !absEnabled)
        else $error("roll feed with absolute detection");
    chk_dog_start: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg.state == SHR_IDLE && startEdge && manualHomeMode && dogReturnEnable && st_reg.dog2
        |=> st_reg.state == SHR_BACK)
        else $error("no return off the dog at start");
    chk_seek_start: assert property (@(posedge sys_clk) disable iff (rst)
        st_reg.state == SHR_IDLE && startEdge && manualHomeMode && dogReturnEnable && !st_reg.dog2
        |=> st_reg.state == SHR_SEEK)
        else $error("home return did not start seeking");
    chk_power_nohome: assert property (@(posedge sys_clk) disable iff (rst)
        powerOnPulse && !homeValid && st_reg.state != SHR_HOMING |=> !homeValid)
        else $error("home created by power-on");
    cov_dog_return: cover property (@(posedge sys_clk) disable iff (rst)
        st_reg.state == SHR_PASS ##[1:1000] homingSeqStart);
    cov_alarm: cover property (@(posedge sys_clk) disable iff (rst) $rose(home_return_incomplete_alarm));
    cov_autopos: cover property (@(posedge sys_clk) disable iff (rst) st_reg.state == SHR_AUTOPOS);
    cov_dog_start: cover property (@(posedge sys_clk) disable iff (rst) st_reg.state == SHR_BACK && st_reg.dog2);
endmodule : shr_home_tracker
